//--- rtl/fault_capture_pkg.sv
// Constants and carrier types for the fault status and fault address block.
// Assumes a 12-bit offset inside the system control space.
package fault_capture_pkg;

    localparam int ADDR_W = 32;
    localparam int OFS_W = 12;

    localparam logic [OFS_W-1:0] FAULT_STATUS_OFS = 12'hd28;
    localparam logic [OFS_W-1:0] HARD_FAULT_STATUS_OFS = 12'hd2c;
    localparam logic [OFS_W-1:0] MEMMANAGE_ADDR_OFS = 12'hd34;
    localparam logic [OFS_W-1:0] BUS_ADDR_OFS = 12'hd38;
    localparam logic [OFS_W-1:0] MPU_FIRST_OFS = 12'hd90;
    localparam logic [OFS_W-1:0] MPU_LAST_OFS = 12'hdbc;

    localparam int FORCED_BIT = 30;
    localparam int VECTOR_READ_BIT = 1;
    localparam int MEMMANAGE_VALID_BIT = 7;
    localparam int BUS_VALID_BIT = 15;

    localparam logic [ADDR_W-1:0] WORD_RESET = 32'h0000_0000;

    // One cycle pulses and addresses reported by the core
    typedef struct packed {
        logic forced_escalation;
        logic vector_read_fault;
        logic [ADDR_W-1:0] preempted_pc;
        logic memmanage_fault;
        logic [ADDR_W-1:0] memmanage_actual_addr;
        logic bus_fault;
        logic [ADDR_W-1:0] bus_request_addr;
    } fault_event_t;

    // System control space access from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic privileged;
        logic [OFS_W-1:0] offset;
        logic [ADDR_W-1:0] wdata;
    } scs_access_t;

endpackage : fault_capture_pkg

//--- rtl/fault_status_address_capture.sv
// Hard fault status flags and the two fault address capture registers.
// Assumes the core presents one access per cycle at most and fault events
// as one-cycle pulses on sys_clk; every answer comes one cycle later.
// Summary of operation
// - Set forced flag when a configurable fault escalates to hard fault.
// - Bit 1 of hard fault status reads 1 after a vector fetch bus fault.
// - On vector read fault, stacked PC is the preempted instruction.
// - Vector read flag clears only by writing 1; writing 0 keeps it.
// - Memory management address register at 0xD34 captures faulting address.
// - Unaligned memory management fault records the actual faulting address.
// - Captured address may be anywhere within the requested access span.
// - Memory management address meaningful only while its valid flag is set.
// - Bus fault address register at 0xD38 captures faulting address.
// - Unaligned bus fault records the address the instruction requested.
// - Bus fault address meaningful only while its valid flag is set.
// - Fault address registers accept only privileged accesses.
// - Memory protection registers accept only privileged accesses too.
`timescale 1ns/1ps
module fault_status_address_capture (
    input wire logic sys_clk,
    input wire logic reset,
    input wire fault_capture_pkg::fault_event_t fault_in,
    input wire fault_capture_pkg::scs_access_t access_in,
    output logic [31:0] read_data_reg,
    output logic access_done_reg,
    output logic access_error_reg,
    output logic [31:0] stacked_pc_reg,
    output logic forced_flag_reg,
    output logic vector_read_flag_reg
);

    logic [31:0] memmanage_fault_address_reg;
    logic [31:0] memmanage_fault_address_next;
    logic [31:0] bus_fault_address_reg;
    logic [31:0] bus_fault_address_next;
    logic memmanage_address_valid_reg;
    logic memmanage_address_valid_next;
    logic bus_address_valid_reg;
    logic bus_address_valid_next;
    logic forced_flag_next;
    logic vector_read_flag_next;
    logic [31:0] stacked_pc_next;
    logic [31:0] read_data_next;
    logic access_done_next;
    logic access_error_next;

    // Everything this block or the protection unit owns needs privilege
    function automatic logic privileged_only(
        input logic [fault_capture_pkg::OFS_W-1:0] ofs
    );
        privileged_only = (ofs == fault_capture_pkg::MEMMANAGE_ADDR_OFS) ||
            (ofs == fault_capture_pkg::BUS_ADDR_OFS) ||
            (ofs == fault_capture_pkg::HARD_FAULT_STATUS_OFS) ||
            (ofs == fault_capture_pkg::FAULT_STATUS_OFS) ||
            ((ofs >= fault_capture_pkg::MPU_FIRST_OFS) &&
             (ofs <= fault_capture_pkg::MPU_LAST_OFS));
    endfunction : privileged_only

    logic allowed;
    logic wr;
    logic [31:0] wd;

    always_comb begin
        allowed = access_in.valid &&
            (access_in.privileged || !privileged_only(access_in.offset));
        wr = allowed && access_in.write;
        wd = access_in.wdata;

        forced_flag_next = forced_flag_reg;
        vector_read_flag_next = vector_read_flag_reg;
        memmanage_fault_address_next = memmanage_fault_address_reg;
        bus_fault_address_next = bus_fault_address_reg;
        memmanage_address_valid_next = memmanage_address_valid_reg;
        bus_address_valid_next = bus_address_valid_reg;
        stacked_pc_next = stacked_pc_reg;
        read_data_next = 32'h0000_0000;
        access_done_next = access_in.valid;
        access_error_next = access_in.valid && !allowed;

        // Software writes first, so a fault in the same cycle overrides them, except an address fault whose valid is already set
        if (wr && access_in.offset == fault_capture_pkg::HARD_FAULT_STATUS_OFS)
        begin
            if (wd[fault_capture_pkg::FORCED_BIT]) begin
                forced_flag_next = 1'b0;
            end
            if (wd[fault_capture_pkg::VECTOR_READ_BIT]) begin
                vector_read_flag_next = 1'b0;
            end
        end else if (wr &&
                     access_in.offset == fault_capture_pkg::FAULT_STATUS_OFS)
        begin
            if (wd[fault_capture_pkg::MEMMANAGE_VALID_BIT]) begin
                memmanage_address_valid_next = 1'b0;
            end
            if (wd[fault_capture_pkg::BUS_VALID_BIT]) begin
                bus_address_valid_next = 1'b0;
            end
        end else if (wr &&
                     access_in.offset == fault_capture_pkg::MEMMANAGE_ADDR_OFS)
        begin
            memmanage_fault_address_next = wd;
        end else if (wr &&
                     access_in.offset == fault_capture_pkg::BUS_ADDR_OFS)
        begin
            bus_fault_address_next = wd;
        end

        if (allowed && !access_in.write) begin
            if (access_in.offset == fault_capture_pkg::HARD_FAULT_STATUS_OFS)
            begin
                read_data_next[fault_capture_pkg::FORCED_BIT] =
                    forced_flag_reg;
                read_data_next[fault_capture_pkg::VECTOR_READ_BIT] =
                    vector_read_flag_reg;
            end else if (access_in.offset ==
                         fault_capture_pkg::FAULT_STATUS_OFS) begin
                read_data_next[fault_capture_pkg::MEMMANAGE_VALID_BIT] =
                    memmanage_address_valid_reg;
                read_data_next[fault_capture_pkg::BUS_VALID_BIT] =
                    bus_address_valid_reg;
            end else if (access_in.offset ==
                         fault_capture_pkg::MEMMANAGE_ADDR_OFS) begin
                read_data_next = memmanage_fault_address_reg;
            end else if (access_in.offset ==
                         fault_capture_pkg::BUS_ADDR_OFS) begin
                read_data_next = bus_fault_address_reg;
            end
        end

        if (fault_in.forced_escalation) begin
            forced_flag_next = 1'b1;
        end
        if (fault_in.vector_read_fault) begin
            vector_read_flag_next = 1'b1;
            stacked_pc_next = fault_in.preempted_pc;
        end
        // The first fault address is kept until software clears its valid
        if (fault_in.memmanage_fault && !memmanage_address_valid_reg) begin
            memmanage_fault_address_next =
                fault_in.memmanage_actual_addr;
            memmanage_address_valid_next = 1'b1;
        end
        if (fault_in.bus_fault && !bus_address_valid_reg) begin
            bus_fault_address_next = fault_in.bus_request_addr;
            bus_address_valid_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            forced_flag_reg <= 1'b0;
            vector_read_flag_reg <= 1'b0;
            memmanage_fault_address_reg <= fault_capture_pkg::WORD_RESET;
            bus_fault_address_reg <= fault_capture_pkg::WORD_RESET;
            memmanage_address_valid_reg <= 1'b0;
            bus_address_valid_reg <= 1'b0;
            stacked_pc_reg <= fault_capture_pkg::WORD_RESET;
            read_data_reg <= fault_capture_pkg::WORD_RESET;
            access_done_reg <= 1'b0;
            access_error_reg <= 1'b0;
        end else begin
            forced_flag_reg <= forced_flag_next;
            vector_read_flag_reg <= vector_read_flag_next;
            memmanage_fault_address_reg <= memmanage_fault_address_next;
            bus_fault_address_reg <= bus_fault_address_next;
            memmanage_address_valid_reg <= memmanage_address_valid_next;
            bus_address_valid_reg <= bus_address_valid_next;
            stacked_pc_reg <= stacked_pc_next;
            read_data_reg <= read_data_next;
            access_done_reg <= access_done_next;
            access_error_reg <= access_error_next;
        end
    end

    a_forced_flag_set: assert property (
        @(posedge sys_clk) disable iff (reset)
        fault_in.forced_escalation |=> forced_flag_reg [*1] ##1
        (forced_flag_reg || $past(access_in.valid && access_in.write)))
        else $error("forced flag not held after escalation");

    a_vector_flag_read: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access_in.valid && access_in.privileged && !access_in.write &&
         access_in.offset == fault_capture_pkg::HARD_FAULT_STATUS_OFS)
        |=> read_data_reg[1] == $past(vector_read_flag_reg))
        else $error("vector read flag readback wrong");

    a_stacked_pc_match: assert property (
        @(posedge sys_clk) disable iff (reset)
        fault_in.vector_read_fault |=>
        (stacked_pc_reg == $past(fault_in.preempted_pc)) &&
        vector_read_flag_reg)
        else $error("stacked pc is not the preempted one");

    a_vector_write_zero: assert property (
        @(posedge sys_clk) disable iff (reset)
        vector_read_flag_reg && !(access_in.valid && access_in.write &&
        access_in.wdata[1]) |=> vector_read_flag_reg)
        else $error("vector read flag lost without a one write");

    a_vector_write_one: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access_in.valid && access_in.write && access_in.privileged &&
         access_in.wdata[1] && !fault_in.vector_read_fault &&
         access_in.offset == fault_capture_pkg::HARD_FAULT_STATUS_OFS)
        |=> !vector_read_flag_reg)
        else $error("vector read flag not cleared by one write");

    a_memmanage_capture: assert property (
        @(posedge sys_clk) disable iff (reset)
        fault_in.memmanage_fault && !memmanage_address_valid_reg |=>
        memmanage_address_valid_reg &&
        memmanage_fault_address_reg == $past(fault_in.memmanage_actual_addr))
        else $error("memory management address not captured");

    a_bus_capture: assert property (
        @(posedge sys_clk) disable iff (reset)
        fault_in.bus_fault && !bus_address_valid_reg |=>
        bus_address_valid_reg &&
        bus_fault_address_reg == $past(fault_in.bus_request_addr))
        else $error("bus fault requested address not captured");

    a_unpriv_refused: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access_in.valid && !access_in.privileged &&
         privileged_only(access_in.offset)) |=>
        access_error_reg && access_done_reg && read_data_reg == 32'h0 &&
        ($stable(bus_fault_address_reg) || $past(fault_in.bus_fault)))
        else $error("unprivileged access was not refused");

    a_mpu_refused: assert property (
        @(posedge sys_clk) disable iff (reset)
        (access_in.valid && !access_in.privileged &&
         access_in.offset >= fault_capture_pkg::MPU_FIRST_OFS &&
         access_in.offset <= fault_capture_pkg::MPU_LAST_OFS) |=>
        access_error_reg)
        else $error("unprivileged protection access was not refused");

endmodule : fault_status_address_capture

//--- test/core_model.sv
// Core-side model that raises fault pulses into the fault capture block.
// Assumes the bench calls fire between clock edges; drives on falling edges.
`timescale 1ns/1ps
module core_model (
    input wire logic sys_clk,
    output fault_capture_pkg::fault_event_t fault_in
);
    initial fault_in = '0;

    // Kind 0 forced, 1 vector read, 2 memmanage, 3 bus fault
    task automatic fire(input int kind, input logic [31:0] addr);
        fault_capture_pkg::fault_event_t ev;
        ev = '0;
        ev.forced_escalation = (kind == 0);
        ev.vector_read_fault = (kind == 1);
        ev.memmanage_fault = (kind == 2);
        ev.bus_fault = (kind == 3);
        ev.preempted_pc = addr;
        // Other address field differs so a wrong pick is seen
        ev.memmanage_actual_addr = (kind == 3) ? ~addr : addr;
        ev.bus_request_addr = (kind == 2) ? ~addr : addr;
        @(negedge sys_clk);
        fault_in <= ev;
        @(negedge sys_clk);
        // Released lines do not keep their last value
        fault_in <= {2'b00, ~addr, 1'b0, ~addr, 1'b0, ~addr};
    endtask : fire
endmodule : core_model

//--- test/fault_status_address_capture_tb.sv
// Self-checking bench for the fault status and fault address block.
// Assumes the core model in core_model.sv and the design package.
`timescale 1ns/1ps
module fault_status_address_capture_tb;
    logic sys_clk, reset;
    fault_capture_pkg::fault_event_t fault_in;
    fault_capture_pkg::scs_access_t access_in;
    logic [31:0] read_data_reg, stacked_pc_reg, seed = 32'hbeed, a;
    logic access_done_reg, access_error_reg, forced_flag_reg;
    logic vector_read_flag_reg, m_mv = 0, m_bv = 0, m_f = 0, m_vr = 0;
    logic [31:0] m_mm = '0, m_bus = '0, m_pc = '0, r;
    logic [11:0] tbl [7] = '{12'hd28, 12'hd2c, 12'hd34, 12'hd38,
        12'hd90, 12'hdbc, 12'h100};
    int failures = 0, n_checks = 0, cycles = 0;

    core_model core (.sys_clk(sys_clk), .fault_in(fault_in));
    fault_status_address_capture dut (.sys_clk(sys_clk), .reset(reset),
        .fault_in(fault_in), .access_in(access_in),
        .read_data_reg(read_data_reg), .access_done_reg(access_done_reg),
        .access_error_reg(access_error_reg),
        .stacked_pc_reg(stacked_pc_reg), .forced_flag_reg(forced_flag_reg),
        .vector_read_flag_reg(vector_read_flag_reg));

    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic flags();
        chk(forced_flag_reg, m_f, "forced");
        chk(vector_read_flag_reg, m_vr, "vector");
        chk(stacked_pc_reg, m_pc, "pc");
    endtask : flags

    task automatic acc(input logic w, p, input logic [11:0] o,
            input logic [31:0] d);
        logic prot;
        logic [31:0] e;
        prot = (o inside {12'hd28, 12'hd2c, 12'hd34, 12'hd38}) ||
            (o >= 12'hd90 && o <= 12'hdbc);
        e = '0;
        if (p) begin
            case (o)
                12'hd28: e = {16'h0, m_bv, 7'h0, m_mv, 7'h0};
                12'hd2c: e = {1'b0, m_f, 28'h0, m_vr, 1'b0};
                12'hd34: e = m_mm;
                12'hd38: e = m_bus;
                default: e = '0;
            endcase
        end
        @(negedge sys_clk);
        // Answers stand one cycle, so the idle cycle before must be quiet
        chk(access_done_reg, 0, "idle done");
        chk(read_data_reg, 0, "idle rdata");
        access_in <= '{1'b1, w, p, o, d};
        @(negedge sys_clk);
        access_in <= '{1'b0, ~w, ~p, ~o, ~d};
        chk(access_done_reg, 1, "done");
        chk(access_error_reg, !p && prot, "error");
        if (!w) chk(read_data_reg, e, "rdata");
        if (w && p) begin
            case (o)
                12'hd28: begin
                    if (d[7]) m_mv = 0;
                    if (d[15]) m_bv = 0;
                end
                12'hd2c: begin
                    if (d[30]) m_f = 0;
                    if (d[1]) m_vr = 0;
                end
                12'hd34: m_mm = d;
                12'hd38: m_bus = d;
                default: ;
            endcase
        end
        flags();
    endtask : acc

    task automatic flt(input int k, input logic [31:0] x);
        core.fire(k, x);
        case (k)
            0: m_f = 1;
            1: begin m_vr = 1; m_pc = x; end
            2: if (!m_mv) begin m_mm = x; m_mv = 1; end
            default: if (!m_bv) begin m_bus = x; m_bv = 1; end
        endcase
        flags();
    endtask : flt

    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    initial begin
        reset = 1;
        access_in = '0;
        repeat (4) @(negedge sys_clk);
        reset = 0;
        foreach (tbl[i]) acc(0, 1, tbl[i], '0);
        flt(0, '0);
        acc(0, 1, 12'hd2c, '0);
        acc(1, 1, 12'hd2c, 32'hbfff_ffff);
        acc(1, 1, 12'hd2c, 32'h4000_0000);
        flt(1, rnd());
        acc(1, 1, 12'hd2c, '0);
        acc(0, 1, 12'hd2c, '0);
        acc(1, 1, 12'hd2c, 32'h2);
        for (int i = 0; i < 2; i++) begin
            a = rnd();
            flt(2 + i, a);
            flt(2 + i, ~a);
            acc(0, 0, tbl[2 + i], '0);
            acc(1, 0, tbl[2 + i], rnd());
            acc(1, 0, 12'hd28, '1);
            acc(0, 1, tbl[2 + i], '0);
            acc(1, 1, 12'hd28, i ? 32'h8000 : 32'h80);
            flt(2 + i, a | 32'h1);
            acc(0, 1, tbl[2 + i], '0);
            acc(1, 1, tbl[2 + i], rnd());
            acc(0, 1, tbl[2 + i], '0);
        end
        repeat (40) begin
            r = rnd();
            if (r[9:8] == 0) flt(r[11:10], rnd());
            else acc(r[0], r[1], tbl[r[6:4] % 7], rnd());
        end
        // Mid-run reset with flags and captures set must wipe them all
        flt(0, '0);
        flt(1, rnd());
        flt(2, rnd());
        @(negedge sys_clk);
        reset = 1;
        @(negedge sys_clk);
        reset = 0;
        m_f = 0;
        m_vr = 0;
        m_mv = 0;
        m_bv = 0;
        m_mm = '0;
        m_bus = '0;
        m_pc = '0;
        flags();
        acc(0, 1, 12'hd28, '0);
        acc(0, 1, 12'hd2c, '0);
        acc(0, 1, 12'hd34, '0);
        end_of_test();
    end
endmodule : fault_status_address_capture_tb
